// ### src/mapc_port.sv
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "mapc_regs.svh"

module mapc_port #(
  parameter int WORD_BITS   = `MAPC_WORD_BITS,
  parameter int HPF_SHIFT   = `MAPC_HPF_SHIFT,
  parameter int PDOWN_CYCLES = `MAPC_PDOWN_CYCLES
) (
  // AHB-Lite slave
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Sample stream from the decimator
  input  wire logic [WORD_BITS-1:0] sample_in,
  input  wire logic                 sample_valid,
  // Control pins
  input  wire logic                 reset_pin_n,
  input  wire logic                 highpass_disable,
  input  wire logic                 mode_low,
  input  wire logic                 mode_high,
  // Audio serial port
  input  wire logic                 bit_clock_i,
  output logic                      bit_clock_o,
  output logic                      bit_clock_oe,
  input  wire logic                 frame_sync_i,
  output logic                      frame_sync_o,
  output logic                      frame_sync_oe,
  output logic                      serial_data,
  // Modulator rate select
  output logic                      mod_osr128
);

  localparam int CW = $clog2(PDOWN_CYCLES + 1);
  localparam int AW = WORD_BITS + HPF_SHIFT;
  localparam int BW = $clog2(WORD_BITS);

  generate
    if (PDOWN_CYCLES <= `MAPC_INIT_CYCLES || WORD_BITS < 2 || HPF_SHIFT < 2
        || `MAPC_CLK_DETECT < 3) begin : g_bad
      $error("mapc_port: unsupported parameter values");
    end
  endgenerate

  // Pin synchronisers.
  mapc_pkg::mapc_pins_t pins_raw;
  mapc_pkg::mapc_pins_t pins;

  assign pins_raw = '{bit_clock: bit_clock_i, frame_sync: frame_sync_i,
                      reset_n: reset_pin_n, highpass_disable: highpass_disable,
                      mode_low: mode_low, mode_high: mode_high};

  mapc_sync #(.WIDTH($bits(mapc_pkg::mapc_pins_t))) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (pins_raw),
    .q       (pins)
  );

  // Sequencer.
  mapc_pkg::mapc_state_t state_q;
  mapc_pkg::mapc_state_t state_d;
  mapc_pkg::mapc_mode_t  mode_q;
  mapc_pkg::mapc_mode_t  mode_dec;
  logic [CW-1:0]         cnt_q;
  logic [CW-1:0]         cnt_d;

  wire in_run     = (state_q == mapc_pkg::ST_RUN);
  wire in_pdown   = (state_q == mapc_pkg::ST_PDOWN);
  wire mode_cap   = (state_q == mapc_pkg::ST_WAIT_CLK) || (state_q == mapc_pkg::ST_HELD)
                    || in_pdown;
  wire is_double  = (mode_q == mapc_pkg::MODE_DOUBLE);
  wire is_lp      = (mode_q == mapc_pkg::MODE_LP);
  wire is_hp      = (mode_q == mapc_pkg::MODE_HP);

  // Both indications high cannot come from a real pin; it falls back to float.
  assign mode_dec = (pins.mode_low && !pins.mode_high) ? mapc_pkg::MODE_DOUBLE :
                    (pins.mode_high && !pins.mode_low) ? mapc_pkg::MODE_LP :
                    mapc_pkg::MODE_HP;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + CW'(1);
    case (state_q)
      mapc_pkg::ST_WAIT_CLK: begin
        // Counting a few edges proves the system clock is running; by then the pin
        // synchroniser has settled, so its reset value cannot fake a held pin.
        if (cnt_q == CW'(`MAPC_CLK_DETECT - 1)) begin
          state_d = pins.reset_n ? mapc_pkg::ST_INIT : mapc_pkg::ST_HELD;
          cnt_d   = '0;
        end
      end
      mapc_pkg::ST_INIT: begin
        if (!pins.reset_n) begin
          state_d = mapc_pkg::ST_HELD;
          cnt_d   = '0;
        end else if (cnt_q == CW'(`MAPC_INIT_CYCLES - 1)) begin
          state_d = mapc_pkg::ST_RUN;
          cnt_d   = '0;
        end
      end
      mapc_pkg::ST_RUN: begin
        cnt_d = '0;
        if (!pins.reset_n) begin
          state_d = mapc_pkg::ST_HELD;
        end
      end
      mapc_pkg::ST_HELD: begin
        if (pins.reset_n) begin
          state_d = mapc_pkg::ST_INIT;
          cnt_d   = '0;
        end else if (cnt_q == CW'(PDOWN_CYCLES - 1)) begin
          state_d = mapc_pkg::ST_PDOWN;
          cnt_d   = '0;
        end
      end
      mapc_pkg::ST_PDOWN: begin
        cnt_d = '0;
        // The clock may have stopped here; the first edge after restart
        // that sees the pin high starts initialisation.
        if (pins.reset_n) begin
          state_d = mapc_pkg::ST_INIT;
        end
      end
      default: begin
        state_d = mapc_pkg::ST_WAIT_CLK;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= mapc_pkg::ST_WAIT_CLK;
      cnt_q   <= '0;
      mode_q  <= mapc_pkg::MODE_HP;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (mode_cap) begin
        mode_q <= mode_dec;
      end
    end
  end

  // Register file.
  logic [31:0] ctrl_q;
  logic        wr_pend_q;
  logic [31:0] waddr_q;
  logic        bck128_q;

  wire        bus_take  = hsel && htrans[1] && hready;
  wire        word_acc  = (hsize == `MAPC_HSIZE_WORD);
  wire        ctrl_hit  = (haddr == `MAPC_ADDR_CTRL);
  wire        stat_hit  = (haddr == `MAPC_ADDR_STATUS);
  wire        master_en = ctrl_q[`MAPC_CTRL_MASTER_BIT];
  wire [31:0] status_v  = {24'h00_0000, master_en, bck128_q, 1'b0,
                           mode_q, state_q};
  wire [31:0] rdata_v   = (ctrl_hit && word_acc) ? ctrl_q :
                          (stat_hit && word_acc) ? status_v : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= `MAPC_CTRL_RESET;
      wr_pend_q <= 1'b0;
      waddr_q   <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= bus_take && hwrite && word_acc;
      if (bus_take) begin
        waddr_q <= haddr;
        hrdata  <= hwrite ? 32'h0000_0000 : rdata_v;
      end
      if (wr_pend_q && waddr_q == `MAPC_ADDR_CTRL) begin
        ctrl_q <= {31'h0000_0000, hwdata[`MAPC_CTRL_MASTER_BIT]};
      end
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // DC-removal filter: a one-pole running mean subtracted from the input.
  logic signed [AW-1:0]        acc_q;
  logic        [WORD_BITS-1:0] hp_sample_q;

  wire [WORD_BITS-1:0] dc_est  = acc_q[AW-1:HPF_SHIFT];
  wire [WORD_BITS:0]   hp_diff = {sample_in[WORD_BITS-1], sample_in}
                                 - {dc_est[WORD_BITS-1], dc_est};
  wire                 hp_ovf  = hp_diff[WORD_BITS] ^ hp_diff[WORD_BITS-1];
  wire [WORD_BITS-1:0] hp_sat  = hp_ovf ?
                                 {hp_diff[WORD_BITS], {(WORD_BITS-1){~hp_diff[WORD_BITS]}}}
                                 : hp_diff[WORD_BITS-1:0];
  wire [AW-1:0]        acc_inc = {{(AW-WORD_BITS-1){hp_diff[WORD_BITS]}}, hp_diff};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q       <= '0;
      hp_sample_q <= '0;
    end else if (!in_run) begin
      acc_q       <= '0;
      hp_sample_q <= '0;
    end else if (sample_valid) begin
      acc_q       <= acc_q + acc_inc;
      hp_sample_q <= pins.highpass_disable ? sample_in : hp_sat;
    end
  end

  // Master timing: one system clock frame holds 512 (normal) or 256 (double).
  logic [8:0] div_q;

  wire [8:0] div_inc   = div_q + 9'h001;
  wire [8:0] div_d     = is_double ? {1'b0, div_inc[7:0]} : div_inc;
  wire       m_bck     = is_lp ? div_q[`MAPC_DIV_BIT_SLOW] : div_q[`MAPC_DIV_BIT_FAST];
  wire       m_fs      = is_double ? ~div_q[7] : ~div_q[8];
  wire       m_fall    = is_lp ? (div_q[2:0] == 3'h0) : (div_q[1:0] == 2'h0);
  wire       m_start   = (div_q == 9'h000);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q         <= 9'h000;
      bit_clock_o   <= 1'b0;
      frame_sync_o  <= 1'b0;
      bit_clock_oe  <= 1'b0;
      frame_sync_oe <= 1'b0;
      mod_osr128    <= 1'b0;
    end else begin
      // Power-down clears the divider and holds it at zero: internal clocks stop.
      div_q         <= in_pdown ? 9'h000 : div_d;
      bit_clock_o   <= !in_pdown && m_bck;
      frame_sync_o  <= !in_pdown && m_fs;
      bit_clock_oe  <= master_en;
      frame_sync_oe <= master_en;
      mod_osr128    <= is_hp;
    end
  end

  // Slave timing from the synchronised pins.
  logic       s_bck_q;
  logic       s_fs_q;
  logic [7:0] s_bits_q;

  wire s_fall    = s_bck_q && !pins.bit_clock;
  wire s_fs_rise = s_fall && !s_fs_q && pins.frame_sync;
  wire s_fs_drop = s_fall && s_fs_q && !pins.frame_sync;
  wire s_invert  = is_lp && bck128_q;
  wire s_start   = s_invert ? s_fs_drop : s_fs_rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_bck_q  <= 1'b0;
      s_fs_q   <= 1'b0;
      s_bits_q <= 8'h00;
      bck128_q <= 1'b0;
    end else begin
      s_bck_q <= pins.bit_clock;
      if (s_fall) begin
        s_fs_q <= pins.frame_sync;
      end
      // Bit clocks per frame sync period tell 64 fs from 128 fs.
      if (s_fs_rise) begin
        s_bits_q <= 8'h01;
        bck128_q <= (s_bits_q >= `MAPC_BCK128_THRESH);
      end else if (s_fall && s_bits_q != 8'hFF) begin
        s_bits_q <= s_bits_q + 8'h01;
      end
    end
  end

  // Shifter shared by both port roles.
  logic [WORD_BITS-1:0] shift_q;
  logic [BW-1:0]        left_q;

  wire f_start  = master_en ? m_start : s_start;
  wire f_shift  = master_en ? m_fall : s_fall;
  // A high performance slave fed 64 fs bit clock stays silent.
  wire out_ok   = in_run && !(is_hp && !master_en && !bck128_q);
  wire f_load   = f_start && out_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_q     <= '0;
      left_q      <= '0;
      serial_data <= 1'b0;
    end else if (!out_ok) begin
      shift_q     <= '0;
      left_q      <= '0;
      serial_data <= 1'b0;
    end else if (f_load) begin
      shift_q     <= hp_sample_q;
      left_q      <= BW'(WORD_BITS - 1);
      serial_data <= hp_sample_q[WORD_BITS-1];
    end else if (f_shift) begin
      shift_q     <= {shift_q[WORD_BITS-2:0], 1'b0};
      left_q      <= (left_q != '0) ? left_q - BW'(1) : left_q;
      serial_data <= (left_q != '0) && shift_q[WORD_BITS-2];
    end
  end

  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_held_to_end;
    (state_q == mapc_pkg::ST_HELD) && (cnt_q == CW'(PDOWN_CYCLES - 1)) && !pins.reset_n;
  endsequence

  AST_INIT_DATA_LOW: assert property (
    (state_q == mapc_pkg::ST_INIT) |-> ##1 !serial_data)
    else $error("data not low during initialisation");

  AST_INIT_LEN: assert property (
    $rose(state_q == mapc_pkg::ST_RUN) |-> $past(cnt_q) == CW'(`MAPC_INIT_CYCLES - 1))
    else $error("initialisation length wrong");

  AST_PDOWN_ENTRY: assert property (
    s_held_to_end |=> (state_q == mapc_pkg::ST_PDOWN) ##1 (!serial_data && !bit_clock_o))
    else $error("power-down entry or quiet outputs wrong");

  AST_REINIT: assert property (
    ((state_q == mapc_pkg::ST_HELD) || in_pdown) && pins.reset_n
    |=> state_q == mapc_pkg::ST_INIT)
    else $error("reset release did not start initialisation");

  AST_MSB_FIRST: assert property (
    f_load |=> serial_data == $past(hp_sample_q[WORD_BITS-1]))
    else $error("first data bit is not the MSB");

  AST_FS_DUTY: assert property (
    in_run && pins.reset_n && master_en && !is_double && div_q == 9'h100
    |=> !frame_sync_o ##1 !frame_sync_o)
    else $error("master frame sync not low in second half");

  AST_BCK_HP: assert property (
    in_run && pins.reset_n && master_en && is_hp && div_q[1:0] == 2'h0
    |=> !bit_clock_o ##2 bit_clock_o)
    else $error("high performance master bit clock wrong");

  AST_HPF_BYPASS: assert property (
    in_run && sample_valid && pins.highpass_disable |=> hp_sample_q == $past(sample_in))
    else $error("bypassed filter changed the sample");

  AST_MODE_DOUBLE: assert property (
    mode_cap && pins.mode_low && !pins.mode_high |=> is_double)
    else $error("low mode pin did not select double speed");

endmodule : mapc_port

// ### src/mapc_regs.svh
`ifndef MAPC_REGS_SVH
`define MAPC_REGS_SVH

// Register map, word aligned on the AHB-Lite slave.
`define MAPC_ADDR_CTRL         32'h0000_0000
`define MAPC_ADDR_STATUS       32'h0000_0004
`define MAPC_CTRL_MASTER_BIT   0
`define MAPC_CTRL_RESET        32'h0000_0000
`define MAPC_HSIZE_WORD        3'h2

// Sample word and frame geometry.
`define MAPC_WORD_BITS         24
`define MAPC_FRAME_NORMAL      128
`define MAPC_FRAME_DOUBLE      64
`define MAPC_BCK128_THRESH     8'h60

// Timing counts in system clock cycles, plus the clock rate in MHz and the minimum reset in ns.
`define MAPC_CLK_DETECT        4
`define MAPC_INIT_CYCLES       1024
`define MAPC_PDOWN_CYCLES      65536
`define MAPC_HCLK_MHZ          200
`define MAPC_RST_MIN_NS        40
`define MAPC_RST_MIN_CYC       ((`MAPC_RST_MIN_NS * `MAPC_HCLK_MHZ + 999) / 1000)

// Master divider: system clock per frame and bit clock divider bit.
`define MAPC_SYS_PER_FS_NORMAL 512
`define MAPC_SYS_PER_FS_DOUBLE 256
`define MAPC_DIV_BIT_FAST      1
`define MAPC_DIV_BIT_SLOW      2

// Corner of fs/48000 with a one-pole estimator: 2^13 is about 48000/(2*pi).
`define MAPC_HPF_SHIFT         13

`endif

// ### src/mapc_pkg.sv
package mapc_pkg;

  typedef enum logic [1:0] {
    MODE_HP,
    MODE_LP,
    MODE_DOUBLE
  } mapc_mode_t;

  typedef enum logic [2:0] {
    ST_WAIT_CLK,
    ST_INIT,
    ST_RUN,
    ST_HELD,
    ST_PDOWN
  } mapc_state_t;

  typedef struct packed {
    logic bit_clock;
    logic frame_sync;
    logic reset_n;
    logic highpass_disable;
    logic mode_low;
    logic mode_high;
  } mapc_pins_t;

endpackage : mapc_pkg

// ### src/mapc_sync.sv
`timescale 1ns/1ps

module mapc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : mapc_sync

// ### tb/mapc_far_end.sv
`timescale 1ns/1ps

module mapc_far_end (
  // Control from the bench
  input  wire logic run,
  input  wire logic fast128,
  // Clocks towards the port
  output logic      bit_clock,
  output logic      frame_sync
);
  int n;

  // The clocks stand still low while not running, so a slave never sees stray edges.
  initial begin
    bit_clock  = 1'b0;
    frame_sync = 1'b0;
    #1.3;
    forever begin
      n = fast128 ? 128 : 64;
      if (!run) begin
        bit_clock  = 1'b0;
        frame_sync = 1'b0;
        #80;
      end else begin
        for (int i = 0; i < n; i++) begin
          bit_clock  = 1'b0;
          frame_sync = (i < n / 2);
          #40;
          bit_clock = 1'b1;
          #40;
        end
      end
    end
  end
endmodule : mapc_far_end

// ### tb/mono_audio_adc_port_control_bench.sv
`timescale 1ns/1ps
`include "mapc_regs.svh"

module mono_audio_adc_port_control_bench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [23:0] sample_in;
  logic        sample_valid, reset_pin_n, highpass_disable, mode_low, mode_high;
  logic        bck_o, bck_oe, fs_o, fs_oe, serial_data, mod_osr128;
  logic        far_bck, far_fs, far_run, far_fast;
  wire logic   bck_pin;
  wire logic   fs_pin;
  logic [87:0] exp_q[$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          nframes = 0;
  localparam logic [3:0] ROWS [8] = '{4'h1, 4'h3, 4'h0, 4'h2, 4'h4, 4'h8, 4'hA, 4'hC};

  assign bck_pin = bck_oe ? bck_o : far_bck;
  assign fs_pin  = fs_oe ? fs_o : far_fs;

  always #2.5 hclk = ~hclk;

  mapc_port #(.PDOWN_CYCLES(2000)) i_mapc_port (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sample_in(sample_in), .sample_valid(sample_valid),
    .reset_pin_n(reset_pin_n), .highpass_disable(highpass_disable), .mode_low(mode_low),
    .mode_high(mode_high), .bit_clock_i(bck_pin), .bit_clock_o(bck_o),
    .bit_clock_oe(bck_oe), .frame_sync_i(fs_pin), .frame_sync_o(fs_o),
    .frame_sync_oe(fs_oe), .serial_data(serial_data), .mod_osr128(mod_osr128)
  );

  mapc_far_end i_mapc_far_end (
    .run(far_run), .fast128(far_fast), .bit_clock(far_bck), .frame_sync(far_fs)
  );

  task automatic report_and_stop();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [87:0] seen, input logic [87:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] rd);
    int n;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= `MAPC_HSIZE_WORD;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin n_fail++; report_and_stop(); end
  endtask : bus

  // Waits for k frame starts and for every noted frame to be compared.
  task automatic settle(input int k);
    int f0, n;
    f0 = nframes;
    n = 0;
    while ((nframes < f0 + k || exp_q.size() > 0) && n < 9000) begin @(posedge hclk); n++; end
    if (n >= 9000) begin n_fail++; report_and_stop(); end
  endtask : settle

  task automatic restart(input logic ml, mh);
    logic [31:0] rd;
    int          n;
    reset_pin_n <= 1'b0;
    mode_low    <= ml;
    mode_high   <= mh;
    repeat (12) @(posedge hclk);
    reset_pin_n <= 1'b1;
    repeat (1020) @(posedge hclk);
    check("data_init", 88'(serial_data), 88'h0);
    bus(1'b0, `MAPC_ADDR_STATUS, 32'h0000_0000, rd);
    check("state_init", 88'(rd[2:0]), 88'h1);
    n = 0;
    do begin bus(1'b0, `MAPC_ADDR_STATUS, 32'h0000_0000, rd); n++; end
      while (rd[2:0] !== 3'h2 && n < 6);
    check("state_run", 88'(rd[2:0]), 88'h2);
  endtask : restart

  // Frame watcher on the pins: word, tail ones, bit clocks, length and high time.
  logic        pb = 1'b0, pfs = 1'b0, started = 1'b0, inv = 1'b0;
  logic [15:0] nb_s = 16'h0, len_s = 16'h0, hi_s = 16'h0, tail_s = 16'h0;
  logic [23:0] w_s = 24'h0;
  always @(posedge hclk) begin
    if (bck_pin && !pb) begin
      if (inv ? (!fs_pin && pfs) : (fs_pin && !pfs)) begin
        if (started && exp_q.size() > 0)
          check("frame", {nb_s, len_s, hi_s, tail_s, w_s}, exp_q.pop_front());
        started = 1'b1;
        {nb_s, len_s, hi_s, tail_s, w_s} = 88'h0;
        nframes++;
      end
      if (nb_s < 16'd24) w_s = {w_s[22:0], serial_data};
      else tail_s += 16'(serial_data);
      nb_s++;
      pfs = fs_pin;
    end
    len_s++;
    hi_s += 16'(fs_pin);
    pb = bck_pin;
  end

  initial begin
    repeat (90000) @(posedge hclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    logic [31:0] rd;
    logic [23:0] s, s0, w;
    logic signed [24:0] dv;
    logic [1:0]  mode;
    logic        m, ml, mh, p, hpd;
    int          nb, len;
    {hclk, hresetn, hsel, hwrite, sample_valid, reset_pin_n, mode_low, mode_high} = 8'h00;
    {far_run, far_fast} = 2'h0;
    highpass_disable = 1'b1;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    sample_in = 24'h00_0000;
    void'($urandom(31922));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `MAPC_ADDR_CTRL, 32'h0000_0000, rd);
    check("ctrl_reset", 88'(rd), 88'(`MAPC_CTRL_RESET));
    bus(1'b0, 32'h0000_0040, 32'h0000_0000, rd);
    check("unmapped", 88'(rd), 88'h0);
    for (int r = 0; r < 8; r++) begin
      {m, ml, mh, p} = ROWS[r];
      mode = (ml && !mh) ? 2'h2 : (mh && !ml) ? 2'h1 : 2'h0;
      nb = m ? ((mode == 2'h0) ? 128 : 64) : (p ? 128 : 64);
      len = m ? ((mode == 2'h2) ? 256 : 512) : nb * 16;
      hpd = 1'(r);
      far_run <= !m;
      far_fast <= p;
      inv <= !m && mode == 2'h1 && p;
      highpass_disable <= hpd;
      restart(ml, mh);
      bus(1'b1, `MAPC_ADDR_CTRL, {31'h0, m}, rd);
      bus(1'b0, `MAPC_ADDR_STATUS, 32'h0000_0000, rd);
      check("mode", 88'({rd[7], rd[4:3]}), 88'({m, mode}));
      check("pins", 88'({mod_osr128, bck_oe, fs_oe}), 88'({mode == 2'h0, m, m}));
      s0 = 24'($urandom);
      s = (r == 4) ? 24'h80_0000 : 24'($urandom);
      // The first sample passes whole; the second loses the first one's DC share.
      dv = 25'($signed({s[23], s}) - ($signed({s0[23], s0}) >>> `MAPC_HPF_SHIFT));
      w = hpd ? s : (dv[24] != dv[23]) ? {dv[24], {23{~dv[24]}}} : dv[23:0];
      sample_in <= s0;
      sample_valid <= 1'b1;
      @(posedge hclk);
      sample_in <= s;
      @(posedge hclk);
      sample_valid <= 1'b0;
      settle(2);
      exp_q.push_back({16'(nb), 16'(len), 16'(len / 2), 16'h0,
                       (!m && mode == 2'h0 && !p) ? 24'h0 : w});
      settle(0);
    end
    reset_pin_n <= 1'b0;
    repeat (1990) @(posedge hclk);
    bus(1'b0, `MAPC_ADDR_STATUS, 32'h0000_0000, rd);
    check("held", 88'(rd[2:0]), 88'h3);
    repeat (40) @(posedge hclk);
    bus(1'b0, `MAPC_ADDR_STATUS, 32'h0000_0000, rd);
    check("pdown", 88'({rd[2:0], serial_data, bck_o, fs_o}), 88'({3'h4, 3'h0}));
    restart(1'b0, 1'b0);
    report_and_stop();
  end
endmodule : mono_audio_adc_port_control_bench
